/* File: dv/tb_top.sv */
// Self-checking bench for the counter gate control block.
// Assumes gate sources and ticks are driven just after a rising clock edge.
`timescale 1ns/10ps
module tb_top;
    import tgc_pkg::*;
    logic clk, rstn, psel, penable, pwrite, count_tick, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, gate_src;
    logic [15:0] count_value, c0;
    int n_mismatch = 0;
    int checks_done = 0;
    tgc_gate_ctrl DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gate_src(gate_src), .count_tick(count_tick), .count_value(count_value), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic ticks(input int n);
        count_tick <= 1'b1;
        repeat (n) @(posedge clk);
        count_tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : ticks
    task automatic gate_to(input logic [3:0] v);
        gate_src <= v;
        repeat (3) @(posedge clk);
    endtask : gate_to
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        apb(1'b0, TGC_GATE_CTRL_OFF, 32'h0);
        check(rd & 32'h0000_00FB, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
    endtask : t_reset
    task automatic t_enable();
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0000_00C0);
        ticks(4);
        check(count_value, 16'h0);
        apb(1'b1, TGC_COUNT_CTRL_OFF, 32'h1);
        ticks(4);
        check(count_value, 16'h0);
        gate_to(4'h1);
        ticks(5);
        check(count_value, 16'h5);
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0000_0080);
        ticks(3);
        check(count_value, 16'h5);
        gate_to(4'h0);
        ticks(2);
        check(count_value, 16'h7);
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0);
        ticks(3);
        check(count_value, 16'hA);
    endtask : t_enable
    task automatic t_sources();
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, TGC_GATE_CTRL_OFF, 32'h40 | s);
            gate_to(4'(1 << s));
            apb(1'b0, TGC_GATE_CTRL_OFF, 32'h0);
            check(rd, 32'h44 | s);
            gate_to(4'h0);
            apb(1'b0, TGC_GATE_CTRL_OFF, 32'h0);
            check(rd, 32'h40 | s);
        end
    endtask : t_sources
    task automatic t_pulse();
        apb(1'b1, TGC_IRQ_MASK_OFF, 32'h1);
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0000_00D8);
        apb(1'b0, TGC_GATE_CTRL_OFF, 32'h0);
        check(rd[3], 1'b1);
        check(irq, 1'b0);
        gate_to(4'h1);
        gate_to(4'h0);
        apb(1'b0, TGC_GATE_CTRL_OFF, 32'h0);
        check(rd[3], 1'b0);
        apb(1'b0, TGC_IRQ_STAT_OFF, 32'h0);
        check(rd[0], 1'b1);
        check(irq, 1'b1);
        apb(1'b1, TGC_IRQ_MASK_OFF, 32'h0);
        check(irq, 1'b0);
        apb(1'b1, TGC_IRQ_STAT_OFF, 32'h1);
        apb(1'b0, TGC_IRQ_STAT_OFF, 32'h0);
        check(rd[0], 1'b0);
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0000_00D8);
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0000_00C0);
        apb(1'b0, TGC_GATE_CTRL_OFF, 32'h0);
        check(rd[3], 1'b0);
    endtask : t_pulse
    task automatic t_toggle();
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0000_00E0);
        c0 = count_value;
        gate_to(4'h1);
        gate_to(4'h0);
        ticks(3);
        check(count_value, 16'(c0 + 3));
        apb(1'b1, TGC_COUNT_CTRL_OFF, 32'h0);
        apb(1'b1, TGC_COUNT_CTRL_OFF, 32'h1);
        ticks(3);
        check(count_value, 16'(c0 + 3));
    endtask : t_toggle
    task automatic t_overflow();
        apb(1'b1, TGC_GATE_CTRL_OFF, 32'h0);
        c0 = count_value;
        pstrb <= 4'h0;
        apb(1'b1, TGC_COUNT_VAL_OFF, 32'h0000_1234);
        pstrb <= 4'h1;
        check(count_value, c0);
        apb(1'b1, TGC_COUNT_VAL_OFF, 32'h0000_FFFE);
        check(count_value, 16'hFFFE);
        ticks(2);
        check(count_value, 16'h0);
        apb(1'b0, TGC_IRQ_STAT_OFF, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, TGC_IRQ_MASK_OFF, 32'h2);
        check(irq, 1'b1);
        apb(1'b1, TGC_IRQ_STAT_OFF, 32'h2);
        check(irq, 1'b0);
    endtask : t_overflow
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h1;
        gate_src = 4'h0;
        count_tick = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_enable();
        t_sources();
        t_pulse();
        t_toggle();
        t_overflow();
        complete_run();
    end
endmodule : tb_top

/* File: dv/tgc_monitor.sv */
// Port checker for the counter gate control block.
// Assumes zero wait state APB as the block answers it.
`timescale 1ns/10ps
module tgc_monitor
    import tgc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_tick,
    input wire logic [CNT_W-1:0] count_value
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr inside {TGC_GATE_CTRL_OFF, TGC_COUNT_CTRL_OFF, TGC_COUNT_VAL_OFF, TGC_IRQ_STAT_OFF,
        TGC_IRQ_MASK_OFF};
    sequence wr_spm_off;
        acc && pwrite && paddr == TGC_GATE_CTRL_OFF && pstrb[0] && !pwdata[TGC_SPM_BIT];
    endsequence
    sequence rd_gate_setup;
        psel && !penable && !pwrite && paddr == TGC_GATE_CTRL_OFF;
    endsequence
    sequence no_count_cause;
        !count_tick && !(acc && pwrite && paddr == TGC_COUNT_VAL_OFF);
    endsequence
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_unmapped: assert property (acc && !hit |-> pslverr) else $error("no error on unmapped");
    chk_err_mapped: assert property (acc && hit |-> !pslverr) else $error("error on mapped");
    chk_rd_unmapped: assert property (acc && !pwrite && !hit |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    chk_count_hold: assert property (no_count_cause |=> $stable(count_value))
        else $error("count moved without tick");
    chk_count_step: assert property (count_tick && !(acc && pwrite) |=>
        (count_value == $past(count_value) || count_value == CNT_W'($past(count_value) + 1'b1)))
        else $error("count step wrong");
    chk_go_cancel: assert property (wr_spm_off ##2 rd_gate_setup |=> !prdata[TGC_GO_BIT])
        else $error("go bit survives cancel");
endmodule : tgc_monitor

bind tgc_gate_ctrl tgc_monitor #(.CNT_W(CNT_W)) u_mon (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_tick(count_tick), .count_value(count_value));

/* File: rtl/tgc_gate_ctrl.sv */
// Counter gate control: 16-bit counter with gate enable, polarity, toggle and single-pulse modes.
// Assumes an APB master on clk and gate sources synchronous to clk.
// Overview of operation
// - With counter off, gate enable is ignored; on, gate enable makes counting gate-dependent.
// - Go/done reads one while single-pulse acquisition is armed and waiting.
// - Go/done reads zero when acquisition finished or never started.
// - Clearing single-pulse mode clears go/done and cancels acquisition.
// - Gate value bit follows the gate signal regardless of gate enable.
// - Gate register layout: enable, polarity, toggle, single, go, value, source.
// - Turning the counter off clears the gate toggle flip-flop.
// - Single-pulse gate falling edge sets gate event flag and clears go/done.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module tgc_gate_ctrl
    import tgc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] gate_src,
    input wire logic count_tick,
    output logic [CNT_W-1:0] count_value,
    output logic irq
);

    initial begin
        if (CNT_W != TGC_CNT_W) begin
            $error("tgc_gate_ctrl: CNT_W must be 16");
        end
        // Status and read mux are sized for two events and a two-bit source field
        if (TGC_IRQ_W != 2 || TGC_SS_W != 2) begin
            $error("tgc_gate_ctrl: package field widths do not match the read mux");
        end
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic wr_gate;
    logic wr_on;
    logic wr_cnt;
    logic wr_stat;
    logic wr_mask;

    assign addr_ok = (paddr == TGC_GATE_CTRL_OFF) || (paddr == TGC_COUNT_CTRL_OFF) ||
                     (paddr == TGC_COUNT_VAL_OFF) || (paddr == TGC_IRQ_STAT_OFF) ||
                     (paddr == TGC_IRQ_MASK_OFF);
    assign pready = 1'b1;
    // Unmapped offsets answer with an error, never with a stall
    assign pslverr = psel && penable && !addr_ok;
    // The byte lane 0 strobe gates every write, including the count value bits in lane 1
    assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
    assign rd_en = psel && !penable && !pwrite;
    assign wr_gate = wr_en && (paddr == TGC_GATE_CTRL_OFF);
    assign wr_on = wr_en && (paddr == TGC_COUNT_CTRL_OFF);
    assign wr_cnt = wr_en && (paddr == TGC_COUNT_VAL_OFF);
    assign wr_stat = wr_en && (paddr == TGC_IRQ_STAT_OFF);
    assign wr_mask = wr_en && (paddr == TGC_IRQ_MASK_OFF);

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic gate_enable_r;
    logic polarity_r;
    logic toggle_mode_r;
    logic spm_r;
    logic [1:0] source_select_r;
    logic counter_on_r;
    logic [TGC_IRQ_W-1:0] irq_mask_r;

    // Go bit is not stored here; it is the acquisition state itself
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gate_enable_r <= TGC_GATE_CTRL_RST[TGC_GE_BIT];
            polarity_r <= TGC_GATE_CTRL_RST[TGC_POL_BIT];
            toggle_mode_r <= TGC_GATE_CTRL_RST[TGC_TM_BIT];
            spm_r <= TGC_GATE_CTRL_RST[TGC_SPM_BIT];
            source_select_r <= TGC_GATE_CTRL_RST[TGC_SS_LSB +: TGC_SS_W];
        end else if (wr_gate) begin
            gate_enable_r <= pwdata[TGC_GE_BIT];
            polarity_r <= pwdata[TGC_POL_BIT];
            toggle_mode_r <= pwdata[TGC_TM_BIT];
            spm_r <= pwdata[TGC_SPM_BIT];
            source_select_r <= pwdata[TGC_SS_LSB +: TGC_SS_W];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_on_r <= 1'b0;
        end else if (wr_on) begin
            counter_on_r <= pwdata[TGC_ON_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_r <= '0;
        end else if (wr_mask) begin
            irq_mask_r <= pwdata[TGC_IRQ_W-1:0];
        end
    end

    // ****************************************************************
    // Gate path
    // ****************************************************************
    logic gate_level;
    logic gate_level_r;
    logic gate_fall;
    logic gate_rise;

    // Polarity is applied before the toggle flop, so toggle sees active edges
    tgc_gate_select #(
        .NUM_SRC(4)
    ) u_gate_select (
        .clk(clk),
        .rstn(rstn),
        .gate_src(gate_src),
        .source_select(source_select_r),
        .polarity(polarity_r),
        .toggle_mode(toggle_mode_r),
        .counter_on(counter_on_r),
        .gate_level(gate_level)
    );

    // Gate value tracked regardless of gate enable
    // Reads zero until the first edge after reset; the pin level is unknown then
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gate_level_r <= 1'b0;
        end else begin
            gate_level_r <= gate_level;
        end
    end

    assign gate_fall = gate_level_r && !gate_level;
    assign gate_rise = gate_level && !gate_level_r;

    // ****************************************************************
    // Single-pulse acquisition
    // ****************************************************************
    tgc_sp_state_t sp_state_r;
    tgc_sp_state_t sp_state_nxt;
    logic go_set;
    logic sp_done;
    logic spm_nxt;
    logic sp_active;

    // Software arms by writing go with single-pulse mode set
    assign go_set = wr_gate && pwdata[TGC_SPM_BIT] && pwdata[TGC_GO_BIT];
    // Mode as it will be after this edge, so enabling and arming may share one write
    assign spm_nxt = wr_gate ? pwdata[TGC_SPM_BIT] : spm_r;
    assign sp_active = (sp_state_r == TGC_SP_ACTIVE);

    always_comb begin
        sp_state_nxt = sp_state_r;
        unique case (sp_state_r)
            TGC_SP_IDLE: begin
                if (go_set) begin
                    sp_state_nxt = TGC_SP_ARMED;
                end
            end
            TGC_SP_ARMED: begin
                if (gate_rise) begin
                    sp_state_nxt = TGC_SP_ACTIVE;
                end
            end
            TGC_SP_ACTIVE: begin
                if (gate_fall) begin
                    sp_state_nxt = TGC_SP_IDLE;
                end
            end
            default: begin
                sp_state_nxt = TGC_SP_IDLE;
            end
        endcase
        if (!spm_nxt) begin
            sp_state_nxt = TGC_SP_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sp_state_r <= TGC_SP_IDLE;
        end else begin
            sp_state_r <= sp_state_nxt;
        end
    end

    assign sp_done = spm_r && sp_active && gate_fall;

    logic go_done;
    // Armed or counting the pulse both read as one; idle reads zero
    assign go_done = (sp_state_r != TGC_SP_IDLE);

    // ****************************************************************
    // Counter
    // ****************************************************************
    logic count_en;
    logic [CNT_W-1:0] count_r;
    logic ovf;
    logic cnt_max;

    // In single-pulse mode the tick that meets the opening edge is lost; plain gating counts it in the same cycle
    always_comb begin
        if (!counter_on_r) begin
            count_en = 1'b0;
        end else if (!gate_enable_r) begin
            count_en = 1'b1;
        end else if (spm_r) begin
            count_en = sp_active && gate_level;
        end else begin
            count_en = gate_level;
        end
    end

    assign cnt_max = (count_r == {CNT_W{1'b1}});
    assign ovf = count_en && count_tick && cnt_max;

    // Bus write beats an increment in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_r <= TGC_CNT_RST;
        end else if (wr_cnt) begin
            count_r <= pwdata[CNT_W-1:0];
        end else if (count_en && count_tick) begin
            count_r <= count_r + 1'b1;
        end
    end

    assign count_value = count_r;

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [TGC_IRQ_W-1:0] irq_stat_r;
    logic [TGC_IRQ_W-1:0] irq_set;
    logic [TGC_IRQ_W-1:0] irq_clr;

    assign irq_set = {ovf, sp_done};
    assign irq_clr = wr_stat ? pwdata[TGC_IRQ_W-1:0] : '0;

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ****************************************************************
    // Read data
    // ****************************************************************
    tgc_gate_ctrl_t gate_view;
    logic [31:0] rdata_nxt;

    always_comb begin
        gate_view.gate_enable = gate_enable_r;
        gate_view.polarity = polarity_r;
        gate_view.toggle_mode = toggle_mode_r;
        gate_view.single_pulse_mode = spm_r;
        gate_view.go_done = go_done;
        gate_view.current_value = gate_level_r;
        gate_view.source_select = source_select_r;
    end

    always_comb begin
        unique case (paddr)
            TGC_GATE_CTRL_OFF: rdata_nxt = {24'h00_0000, gate_view};
            TGC_COUNT_CTRL_OFF: rdata_nxt = {31'h0000_0000, counter_on_r};
            TGC_COUNT_VAL_OFF: rdata_nxt = {16'h0000, count_r};
            TGC_IRQ_STAT_OFF: rdata_nxt = {30'h0000_0000, irq_stat_r};
            TGC_IRQ_MASK_OFF: rdata_nxt = {30'h0000_0000, irq_mask_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Loaded in the setup cycle, so the access phase needs no wait state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= rdata_nxt;
        end
    end

endmodule : tgc_gate_ctrl

/* File: rtl/tgc_gate_select.sv */
// Gate source multiplexer with polarity and optional toggle flip-flop.
// Assumes gate sources already synchronous to clk.
`timescale 1ns/10ps
module tgc_gate_select
    import tgc_pkg::*;
#(
    parameter int NUM_SRC = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [NUM_SRC-1:0] gate_src,
    input wire logic [1:0] source_select,
    input wire logic polarity,
    input wire logic toggle_mode,
    input wire logic counter_on,
    output logic gate_level
);

    initial begin
        if (NUM_SRC != 4) begin
            $error("tgc_gate_select: NUM_SRC must be 4");
        end
    end

    logic sel_raw;
    logic pol_level;
    logic pol_level_r;
    logic tog_r;

    assign sel_raw = gate_src[source_select];
    assign pol_level = polarity ? sel_raw : ~sel_raw;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pol_level_r <= 1'b0;
        end else begin
            pol_level_r <= pol_level;
        end
    end

    // Toggle flop flips on each rising active edge; held clear when off
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tog_r <= 1'b0;
        end else if (!counter_on || !toggle_mode) begin
            tog_r <= 1'b0;
        end else if (pol_level && !pol_level_r) begin
            tog_r <= ~tog_r;
        end
    end

    assign gate_level = toggle_mode ? tog_r : pol_level;

endmodule : tgc_gate_select

/* File: rtl/tgc_pkg.sv */
// Package for the counter gate control block: register map, field positions, reset values, types.
// Assumes a 32-bit APB slave with word-aligned registers.
package tgc_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] TGC_GATE_CTRL_OFF = 8'h00;
    localparam logic [7:0] TGC_COUNT_CTRL_OFF = 8'h04;
    localparam logic [7:0] TGC_COUNT_VAL_OFF = 8'h08;
    localparam logic [7:0] TGC_IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] TGC_IRQ_MASK_OFF = 8'h10;

    // ****************************************************************
    // Gate control register fields
    // ****************************************************************
    localparam int TGC_GE_BIT = 7;
    localparam int TGC_POL_BIT = 6;
    localparam int TGC_TM_BIT = 5;
    localparam int TGC_SPM_BIT = 4;
    localparam int TGC_GO_BIT = 3;
    localparam int TGC_VAL_BIT = 2;
    localparam int TGC_SS_LSB = 0;
    localparam int TGC_SS_W = 2;
    localparam logic [7:0] TGC_GATE_CTRL_RST = 8'h00;

    // Count control register: bit 0 counter on
    localparam int TGC_ON_BIT = 0;

    // Interrupt status/mask: bit 0 gate event, bit 1 counter overflow
    localparam int TGC_IRQ_GATE_BIT = 0;
    localparam int TGC_IRQ_OVF_BIT = 1;
    localparam int TGC_IRQ_W = 2;

    localparam int TGC_CNT_W = 16;
    localparam logic [15:0] TGC_CNT_RST = 16'h0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic gate_enable;
        logic polarity;
        logic toggle_mode;
        logic single_pulse_mode;
        logic go_done;
        logic current_value;
        logic [1:0] source_select;
    } tgc_gate_ctrl_t;

    typedef enum logic [1:0] {
        TGC_SP_IDLE = 2'b00,
        TGC_SP_ARMED = 2'b01,
        TGC_SP_ACTIVE = 2'b10
    } tgc_sp_state_t;

endpackage : tgc_pkg
